// ===== hw/desc_channel.sv
// Device end: descriptor fetch, header decode and pointer walk
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module desc_channel import desc_pkg::*; (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Channel configuration
   input wire logic IRQ_EN,
   input wire logic WB_EN,
   // Host-controlled test path
   input wire logic HOST_WR_VALID,
   input wire logic [DATA_W-1:0] HOST_WR_DATA,
   // Result data stored by the output slot
   input wire logic [DATA_W-1:0] RESULT_DATA,
   // Decoded header
   output logic [3:0] PRIMARY_SEL,
   output logic [DATA_W-1:0] PRIMARY_MODE_REG,
   output logic [3:0] SECONDARY_SEL,
   output logic [DATA_W-1:0] SECONDARY_MODE_REG,
   output logic [4:0] DESCRIPTOR_TYPE,
   output logic NEWER_TYPE,
   output logic INBOUND,
   output logic UNIT_START,
   // Unit data and length writes
   output logic UNIT_VALID,
   output logic [DATA_W-1:0] UNIT_DATA,
   output logic LEN_VALID,
   output logic [LEN_W-1:0] LEN_VALUE,
   output logic [6:0] EXTENT,
   // Status
   output logic HDR_ERR,
   output logic SG_ERR,
   output logic DONE_IRQ,
   output logic BUSY,
   // Link
   desc_link_if.dev lnk
);
   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_DESC = 7'h02,
      S_CHECK = 7'h04,
      S_PTR = 7'h08,
      S_LINK = 7'h10,
      S_XFER = 7'h20,
      S_WBACK = 7'h40
   } cstate_t;

   typedef struct packed {
      cstate_t state;
      logic fq_ready;
      logic req;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [ADDR_W-1:0] desc_addr;
      logic [2:0] idx;
      logic [7:0][DATA_W-1:0] dbuf;
      logic [2:0] slot;
      logic [ADDR_W-1:0] seg_addr;
      logic [LEN_W-1:0] remain;
      logic [ADDR_W-1:0] link_ptr;
      logic in_link;
      logic last_link;
      logic [3:0] psel;
      logic [7:0] pmode;
      logic [3:0] ssel;
      logic [7:0] smode;
      logic [4:0] dtype;
      logic newer;
      logic inbound;
      logic start;
      logic unit_valid;
      logic [DATA_W-1:0] unit_data;
      logic len_valid;
      logic [LEN_W-1:0] len;
      logic [6:0] extent;
      logic hdr_err;
      logic sg_err;
      logic done_irq;
      logic busy;
   } chstate_t;
   chstate_t q, n;

   function automatic logic type_known(input logic [4:0] t);
      unique case (t)
         T_AES_CTR, T_COMMON, T_HMAC_SNOOP, T_COMMON_STREAM, T_HMAC_CTR: return 1'b1;
         T_PK_MONT, T_EC_ASM, T_EC_MUL, T_EC_ADD: return 1'b1;
         T_IPSEC, T_CCMP, T_SRTP, T_TLS_BLOCK, T_TLS_STREAM, T_XOR: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : type_known

   function automatic logic header_bad(input logic [3:0] p, input logic [3:0] s,
                                       input logic [4:0] t);
      logic bad;
      bad = (p == UNIT_NONE) || (p > UNIT_AES);
      if (s != UNIT_NONE && s != UNIT_DIGEST) begin
         bad = 1'b1;
      end
      if (s == UNIT_DIGEST && !(p == UNIT_DES || p == UNIT_AES || p == UNIT_STREAM)) begin
         bad = 1'b1;
      end
      if (!type_known(t)) begin
         bad = 1'b1;
      end
      return bad;
   endfunction : header_bad

   logic [DATA_W-1:0] hdr;
   logic [DATA_W-1:0] pd;
   logic [LEN_W-1:0] rem_next;
   logic beat_go;
   logic finish;

   always_comb begin
      n = q;
      hdr = q.dbuf[0];
      pd = q.dbuf[q.slot + 3'h1];
      rem_next = (q.remain > BEAT_BYTES) ? q.remain - BEAT_BYTES : '0;
      beat_go = 1'b0;
      finish = 1'b0;
      n.unit_valid = 1'b0;
      n.len_valid = 1'b0;
      n.start = 1'b0;
      n.hdr_err = 1'b0;
      n.sg_err = 1'b0;
      n.done_irq = 1'b0;
      if (q.req && lnk.ack) begin
         n.req = 1'b0;
      end
      // Test path only while no descriptor owns the unit port
      if (HOST_WR_VALID && q.state == S_IDLE) begin
         n.unit_valid = 1'b1;
         n.unit_data = HOST_WR_DATA;
      end
      unique case (q.state)
         S_IDLE: begin
            if (lnk.fq_valid && q.fq_ready) begin
               n.fq_ready = 1'b0;
               n.desc_addr = lnk.fq_addr;
               n.idx = '0;
               n.req = 1'b1;
               n.we = 1'b0;
               n.addr = lnk.fq_addr;
               n.busy = 1'b1;
               n.state = S_DESC;
            end
         end
         S_DESC: begin
            if (q.req && lnk.ack) begin
               n.dbuf[q.idx] = lnk.rdata;
               if (q.idx == LAST_DWORD) begin
                  n.state = S_CHECK;
               end else begin
                  n.idx = q.idx + 3'h1;
                  n.req = 1'b1;
                  n.addr = q.addr + DWORD_BYTES;
               end
            end
         end
         S_CHECK: begin
            n.psel = hdr[PSEL_LSB +: 4];
            n.pmode = hdr[PMODE_LSB +: 8];
            n.ssel = hdr[SSEL_LSB +: 4];
            n.smode = hdr[SMODE_LSB +: 8];
            n.dtype = hdr[TYPE_LSB +: 5];
            n.newer = hdr[TYPE_LSB];
            n.inbound = hdr[DIR_BIT];
            if (header_bad(hdr[PSEL_LSB +: 4], hdr[SSEL_LSB +: 4], hdr[TYPE_LSB +: 5])) begin
               n.hdr_err = 1'b1;
               n.state = S_IDLE;
               n.fq_ready = 1'b1;
               n.busy = 1'b0;
            end else begin
               n.start = 1'b1;
               n.slot = '0;
               n.state = S_PTR;
            end
         end
         S_PTR: begin
            if (q.slot == SLOT_END) begin
               finish = 1'b1;
            end else if (pd[LEN_LSB +: LEN_W] == '0) begin
               n.slot = q.slot + 3'h1;
            end else begin
               n.len_valid = 1'b1;
               n.len = pd[LEN_LSB +: LEN_W];
               n.extent = pd[EXT_LSB +: 7];
               if (pd[PTR_LSB +: ADDR_W] == '0) begin
                  // Length alone goes to the unit, nothing is fetched
                  n.slot = q.slot + 3'h1;
               end else if (pd[JUMP_BIT]) begin
                  n.link_ptr = pd[PTR_LSB +: ADDR_W];
                  n.in_link = 1'b1;
                  n.req = 1'b1;
                  n.we = 1'b0;
                  n.addr = pd[PTR_LSB +: ADDR_W];
                  n.state = S_LINK;
               end else begin
                  n.in_link = 1'b0;
                  n.seg_addr = pd[PTR_LSB +: ADDR_W];
                  n.remain = pd[LEN_LSB +: LEN_W];
                  beat_go = 1'b1;
                  n.state = S_XFER;
               end
            end
         end
         S_LINK: begin
            if (q.req && lnk.ack) begin
               if (lnk.rdata[NEXT_BIT]) begin
                  n.link_ptr = lnk.rdata[PTR_LSB +: ADDR_W];
                  n.req = 1'b1;
                  n.addr = lnk.rdata[PTR_LSB +: ADDR_W];
               end else if (lnk.rdata[LEN_LSB +: LEN_W] == '0) begin
                  // Empty segment aborts the descriptor
                  n.sg_err = 1'b1;
                  n.state = S_IDLE;
                  n.fq_ready = 1'b1;
                  n.busy = 1'b0;
               end else begin
                  n.seg_addr = lnk.rdata[PTR_LSB +: ADDR_W];
                  n.remain = lnk.rdata[LEN_LSB +: LEN_W];
                  n.last_link = lnk.rdata[RET_BIT];
                  n.link_ptr = q.link_ptr + DWORD_BYTES;
                  beat_go = 1'b1;
                  n.state = S_XFER;
               end
            end
         end
         S_XFER: begin
            if (q.req && lnk.ack) begin
               if (!q.we) begin
                  n.unit_valid = 1'b1;
                  n.unit_data = lnk.rdata;
               end
               n.remain = rem_next;
               if (rem_next != '0) begin
                  n.seg_addr = q.seg_addr + DWORD_BYTES;
                  beat_go = 1'b1;
               end else if (q.in_link && !q.last_link) begin
                  n.req = 1'b1;
                  n.we = 1'b0;
                  n.addr = q.link_ptr;
                  n.state = S_LINK;
               end else begin
                  n.slot = q.slot + 3'h1;
                  n.state = S_PTR;
               end
            end
         end
         S_WBACK: begin
            if (q.req && lnk.ack) begin
               n.state = S_IDLE;
               n.fq_ready = 1'b1;
               n.busy = 1'b0;
            end
         end
      endcase
      if (beat_go) begin
         n.req = 1'b1;
         n.we = (q.slot == OUT_SLOT);
         n.addr = n.seg_addr;
         n.wdata = RESULT_DATA;
      end
      if (finish) begin
         n.done_irq = hdr[DN_BIT] && IRQ_EN;
         if (hdr[DN_BIT] && WB_EN) begin
            n.req = 1'b1;
            n.we = 1'b1;
            n.addr = q.desc_addr;
            n.wdata = {hdr[DATA_W-1:MARK_W], WB_MARK};
            n.state = S_WBACK;
         end else begin
            n.state = S_IDLE;
            n.fq_ready = 1'b1;
            n.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         q <= '0;
         q.state <= S_IDLE;
         q.fq_ready <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // Mode byte lands in the top byte of the unit's mode register
   assign PRIMARY_MODE_REG = {q.pmode, {MODE_REG_LSB{1'b0}}};
   assign SECONDARY_MODE_REG = {q.smode, {MODE_REG_LSB{1'b0}}};
   assign PRIMARY_SEL = q.psel;
   assign SECONDARY_SEL = q.ssel;
   assign DESCRIPTOR_TYPE = q.dtype;
   assign NEWER_TYPE = q.newer;
   assign INBOUND = q.inbound;
   assign UNIT_START = q.start;
   assign UNIT_VALID = q.unit_valid;
   assign UNIT_DATA = q.unit_data;
   assign LEN_VALID = q.len_valid;
   assign LEN_VALUE = q.len;
   assign EXTENT = q.extent;
   assign HDR_ERR = q.hdr_err;
   assign SG_ERR = q.sg_err;
   assign DONE_IRQ = q.done_irq;
   assign BUSY = q.busy;
   assign lnk.fq_ready = q.fq_ready;
   assign lnk.req = q.req;
   assign lnk.we = q.we;
   assign lnk.addr = q.addr;
   assign lnk.wdata = q.wdata;
endmodule : desc_channel

// ===== hw/desc_pkg.sv
// Shared constants for the descriptor fetch and decode link
package desc_pkg;
   // Widths
   localparam int DATA_W = 64;
   localparam int ADDR_W = 32;
   localparam int LEN_W = 16;
   localparam int AVS_AW = 5;
   localparam int AVS_DW = 32;
   // Descriptor geometry
   localparam logic [2:0] LAST_DWORD = 3'h7;
   localparam logic [2:0] OUT_SLOT = 3'h6;
   localparam logic [2:0] SLOT_END = 3'h7;
   localparam logic [ADDR_W-1:0] DWORD_BYTES = 32'h0000_0008;
   localparam logic [LEN_W-1:0] BEAT_BYTES = 16'h0008;
   // Header fields
   localparam int PSEL_LSB = 0;
   localparam int PMODE_LSB = 4;
   localparam int SSEL_LSB = 12;
   localparam int SMODE_LSB = 16;
   localparam int TYPE_LSB = 24;
   localparam int DIR_BIT = 30;
   localparam int DN_BIT = 31;
   localparam int MARK_W = 8;
   localparam logic [7:0] WB_MARK = 8'hFF;
   localparam int MODE_REG_LSB = 56;
   // Pointer dword fields
   localparam int LEN_LSB = 0;
   localparam int JUMP_BIT = 16;
   localparam int EXT_LSB = 17;
   localparam int PTR_LSB = 32;
   // Link table entry fields
   localparam int RET_BIT = 22;
   localparam int NEXT_BIT = 23;
   // Execution unit select codes
   localparam logic [3:0] UNIT_NONE = 4'h0;
   localparam logic [3:0] UNIT_STREAM = 4'h1;
   localparam logic [3:0] UNIT_DES = 4'h2;
   localparam logic [3:0] UNIT_DIGEST = 4'h3;
   localparam logic [3:0] UNIT_RANDOM = 4'h4;
   localparam logic [3:0] UNIT_PUBKEY = 4'h5;
   localparam logic [3:0] UNIT_AES = 4'h6;
   localparam logic [3:0] UNIT_WB_MARK = 4'hF;
   // Descriptor type codes, last bit marks the newer group
   localparam logic [4:0] T_AES_CTR = 5'h00;
   localparam logic [4:0] T_COMMON = 5'h02;
   localparam logic [4:0] T_HMAC_SNOOP = 5'h04;
   localparam logic [4:0] T_COMMON_STREAM = 5'h0A;
   localparam logic [4:0] T_PK_MONT = 5'h10;
   localparam logic [4:0] T_HMAC_CTR = 5'h18;
   localparam logic [4:0] T_IPSEC = 5'h01;
   localparam logic [4:0] T_CCMP = 5'h03;
   localparam logic [4:0] T_SRTP = 5'h05;
   localparam logic [4:0] T_EC_ASM = 5'h07;
   localparam logic [4:0] T_EC_MUL = 5'h09;
   localparam logic [4:0] T_EC_ADD = 5'h0B;
   localparam logic [4:0] T_TLS_BLOCK = 5'h11;
   localparam logic [4:0] T_TLS_STREAM = 5'h13;
   localparam logic [4:0] T_XOR = 5'h15;
   // Host register byte offsets
   localparam logic [AVS_AW-1:0] REG_FETCH = 5'h00;
   localparam logic [AVS_AW-1:0] REG_STATUS = 5'h04;
   localparam logic [AVS_AW-1:0] REG_INDEX = 5'h08;
   localparam logic [AVS_AW-1:0] REG_LO = 5'h0C;
   localparam logic [AVS_AW-1:0] REG_HI = 5'h10;
endpackage : desc_pkg

// ===== hw/desc_link_if.sv
// Fetch queue and memory bus between host and descriptor channel
`timescale 1ns/1ps
interface desc_link_if;
   import desc_pkg::*;
   logic fq_valid;
   logic [ADDR_W-1:0] fq_addr;
   logic fq_ready;
   logic req;
   logic we;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   logic ack;
   modport dev (input fq_valid, fq_addr, rdata, ack, output fq_ready, req, we, addr, wdata);
   modport host (output fq_valid, fq_addr, rdata, ack, input fq_ready, req, we, addr, wdata);
endinterface : desc_link_if

// ===== hw/desc_host.sv
// Host end: fetch queue, descriptor memory and Avalon register port
`timescale 1ns/1ps
module desc_host import desc_pkg::*; #(
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Avalon-MM slave
   input wire logic [AVS_AW-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [AVS_DW-1:0] AVS_WRITEDATA,
   output logic [AVS_DW-1:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // Link
   desc_link_if.host lnk
);
   localparam int IW = $clog2(DEPTH);
   typedef struct packed {
      logic wait_r;
      logic [AVS_DW-1:0] avs_rdata;
      logic fq_valid;
      logic [ADDR_W-1:0] fq_addr;
      logic [IW-1:0] index;
      logic [AVS_DW-1:0] lo_stage;
      logic ack;
      logic [DATA_W-1:0] rdata;
      logic [DEPTH-1:0][DATA_W-1:0] mem;
   } hstate_t;
   hstate_t q, n;
   logic [IW-1:0] link_idx;
   logic [DATA_W-1:0] cur;

   always_comb begin
      n = q;
      link_idx = lnk.addr[3 +: IW];
      cur = q.mem[q.index];
      n.ack = 1'b0;
      // Read value is captured first, write lands one edge later with waitrequest low
      if ((AVS_READ || AVS_WRITE) && q.wait_r) begin
         n.wait_r = 1'b0;
         unique case (AVS_ADDRESS)
            REG_STATUS: n.avs_rdata = AVS_DW'({q.index, 7'h00, q.fq_valid});
            REG_INDEX: n.avs_rdata = AVS_DW'(q.index);
            REG_LO: n.avs_rdata = cur[AVS_DW-1:0];
            REG_HI: n.avs_rdata = cur[DATA_W-1:AVS_DW];
            default: n.avs_rdata = '0;
         endcase
      end else begin
         n.wait_r = 1'b1;
      end
      if (AVS_WRITE && !q.wait_r) begin
         unique case (AVS_ADDRESS)
            REG_FETCH: begin
               // Single entry queue: a second address while one is pending is dropped
               if (!q.fq_valid) begin
                  n.fq_valid = 1'b1;
                  n.fq_addr = AVS_WRITEDATA;
               end
            end
            REG_INDEX: n.index = AVS_WRITEDATA[IW-1:0];
            REG_LO: n.lo_stage = AVS_WRITEDATA;
            REG_HI: begin
               n.mem[q.index] = {AVS_WRITEDATA, q.lo_stage};
               n.index = q.index + 1'b1;
            end
            default: ;
         endcase
      end
      if (q.fq_valid && lnk.fq_ready) begin
         n.fq_valid = 1'b0;
      end
      // Channel writes win over a same-cycle software write to the same word
      if (lnk.req && !q.ack) begin
         n.ack = 1'b1;
         n.rdata = q.mem[link_idx];
         if (lnk.we) begin
            n.mem[link_idx] = lnk.wdata;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         q <= '0;
         q.wait_r <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign AVS_READDATA = q.avs_rdata;
   assign AVS_WAITREQUEST = q.wait_r;
   assign lnk.fq_valid = q.fq_valid;
   assign lnk.fq_addr = q.fq_addr;
   assign lnk.ack = q.ack;
   assign lnk.rdata = q.rdata;
endmodule : desc_host

// ===== dv/desc_assertions.sv
// Link protocol checks between the host and channel ends
`timescale 1ns/1ps
module desc_assertions import desc_pkg::*; (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Link
   input wire logic fq_valid,
   input wire logic [ADDR_W-1:0] fq_addr,
   input wire logic fq_ready,
   input wire logic req,
   input wire logic we,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic ack
);
   logic [ADDR_W-1:0] base_q;
   logic [3:0] rd_cnt_q;
   logic [DATA_W-1:0] hdr_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // Count of 8 means no descriptor fetch in progress
   always_ff @(posedge CLK) begin
      if (RST) begin
         base_q <= '0;
         rd_cnt_q <= 4'h8;
         hdr_q <= '0;
      end else if (fq_valid && fq_ready) begin
         base_q <= fq_addr;
         rd_cnt_q <= 4'h0;
      end else if (req && !we && ack && rd_cnt_q < 4'h8) begin
         if (rd_cnt_q == 4'h0) begin
            hdr_q <= rdata;
         end
         rd_cnt_q <= rd_cnt_q + 4'h1;
      end
   end
   fetch_take_a: assert property (fq_valid && fq_ready |=> !fq_valid && !fq_ready)
      else $error("Fetch handshake not closed");
   fetch_hold_a: assert property (fq_valid && !fq_ready |=> fq_valid && $stable(fq_addr))
      else $error("Queued address not held");
   fetch_start_a: assert property (fq_valid && fq_ready |-> ##[1:3] (req && !we))
      else $error("Descriptor read not started");
   desc_addr_a: assert property (req && !we && rd_cnt_q < 4'h8 |->
      addr == base_q + 32'(rd_cnt_q) * DWORD_BYTES)
      else $error("Descriptor dword address wrong");
   req_hold_a: assert property (req && !ack |=>
      req && $stable(addr) && $stable(we) && $stable(wdata))
      else $error("Request changed before answer");
   ack_answer_a: assert property (req && !ack |=> ack)
      else $error("Memory answer late");
   ack_pulse_a: assert property (ack |-> $past(req) && !$past(ack))
      else $error("Answer without request");
   idle_quiet_a: assert property (fq_ready |-> !req)
      else $error("Bus request while idle");
   wb_mark_a: assert property (req && we && rd_cnt_q == 4'h8 && addr == base_q |->
      wdata == {hdr_q[DATA_W-1:MARK_W], WB_MARK})
      else $error("Writeback value wrong");
   cover property (fq_valid && fq_ready);
   cover property (req && we && ack);
   cover property (req && we && rd_cnt_q == 4'h8 && addr == base_q);
endmodule : desc_assertions

// ===== dv/tb_top.sv
// Self-checking bench for the host and channel pair
`timescale 1ns/1ps
module tb_top;
   import desc_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [AVS_AW-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [AVS_DW-1:0] avs_writedata = '0;
   logic [AVS_DW-1:0] avs_readdata, junk;
   logic avs_waitrequest, irq_en, wb_en, host_wr_valid;
   logic [DATA_W-1:0] host_wr_data, result_data, pm_reg, sm_reg, unit_data, rd;
   logic [3:0] psel, ssel, ps, ss;
   logic [4:0] dtype;
   logic newer, inbound, unit_start, unit_valid, len_valid, hdr_err, sg_err, done_irq, busy;
   logic [LEN_W-1:0] len_value;
   logic [6:0] extent;
   logic [7:0] pm;
   int err_total = 0;
   int checks_done = 0;
   int n_start, n_err, n_sg, n_done;
   logic [DATA_W-1:0] unit_q[$];
   logic [22:0] len_q[$];
   logic [DATA_W-1:0] d[8];
   logic [4:0] types[15] = '{T_AES_CTR, T_COMMON, T_HMAC_SNOOP, T_COMMON_STREAM, T_PK_MONT,
      T_HMAC_CTR, T_IPSEC, T_CCMP, T_SRTP, T_EC_ASM, T_EC_MUL, T_EC_ADD, T_TLS_BLOCK,
      T_TLS_STREAM, T_XOR};
   // Primary select, secondary select, type
   logic [12:0] bad[10] = '{{4'h0, 4'h0, T_IPSEC}, {4'h7, 4'h0, T_IPSEC}, {4'hF, 4'h0, T_IPSEC},
      {4'h2, 4'h1, T_IPSEC}, {4'h2, 4'h2, T_IPSEC}, {4'h4, 4'h3, T_IPSEC},
      {4'h5, 4'h3, T_IPSEC}, {4'h6, 4'h0, 5'h06}, {4'h1, 4'h0, 5'h0D}, {4'h2, 4'h0, 5'h1F}};

   desc_link_if desc_link_if_i ();
   desc_host desc_host_i (.CLK(CLK), .RST(RST), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .lnk(desc_link_if_i));
   desc_channel desc_channel_i (.CLK(CLK), .RST(RST), .IRQ_EN(irq_en), .WB_EN(wb_en),
      .HOST_WR_VALID(host_wr_valid), .HOST_WR_DATA(host_wr_data), .RESULT_DATA(result_data),
      .PRIMARY_SEL(psel), .PRIMARY_MODE_REG(pm_reg), .SECONDARY_SEL(ssel),
      .SECONDARY_MODE_REG(sm_reg), .DESCRIPTOR_TYPE(dtype), .NEWER_TYPE(newer), .INBOUND(inbound),
      .UNIT_START(unit_start), .UNIT_VALID(unit_valid), .UNIT_DATA(unit_data),
      .LEN_VALID(len_valid), .LEN_VALUE(len_value), .EXTENT(extent), .HDR_ERR(hdr_err),
      .SG_ERR(sg_err), .DONE_IRQ(done_irq), .BUSY(busy), .lnk(desc_link_if_i));
   desc_assertions desc_assertions_i (.CLK(CLK), .RST(RST),
      .fq_valid(desc_link_if_i.fq_valid), .fq_addr(desc_link_if_i.fq_addr),
      .fq_ready(desc_link_if_i.fq_ready), .req(desc_link_if_i.req), .we(desc_link_if_i.we),
      .addr(desc_link_if_i.addr), .wdata(desc_link_if_i.wdata),
      .rdata(desc_link_if_i.rdata), .ack(desc_link_if_i.ack));

   always #20 CLK = ~CLK;
   // Pulses are one cycle wide, so count them at every edge
   always @(posedge CLK) begin
      if (unit_start === 1'b1) n_start++;
      if (hdr_err === 1'b1) n_err++;
      if (sg_err === 1'b1) n_sg++;
      if (done_irq === 1'b1) n_done++;
      if (unit_valid === 1'b1) unit_q.push_back(unit_data);
      if (len_valid === 1'b1) len_q.push_back({extent, len_value});
   end

   function automatic logic [63:0] hdr(input logic [3:0] p, input logic [7:0] pmd,
         input logic [3:0] s, input logic [7:0] smd, input logic [4:0] t, input logic dr,
         input logic dn);
      return {32'h0000_0000, dn, dr, 1'b0, t, smd, s, pmd, p};
   endfunction : hdr

   function automatic logic [63:0] ptr(input logic [15:0] len, input logic j,
         input logic [6:0] ext, input logic [31:0] p);
      return {p, 8'h00, ext, j, len};
   endfunction : ptr

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("Mismatches %0d, comparisons %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   // Holds the request until waitrequest is seen low at an edge
   task automatic avs(input logic [AVS_AW-1:0] a, input logic wr, input logic [31:0] wd,
         output logic [31:0] q);
      int n;
      n = 0;
      @(posedge CLK);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= wd;
      do begin
         @(posedge CLK);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      if (n >= 50) err_total++;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : avs

   task automatic put(input int idx, input logic [63:0] v);
      avs(REG_INDEX, 1'b1, 32'(idx), junk);
      avs(REG_LO, 1'b1, v[31:0], junk);
      avs(REG_HI, 1'b1, v[63:32], junk);
   endtask : put

   task automatic get(input int idx);
      avs(REG_INDEX, 1'b1, 32'(idx), junk);
      avs(REG_LO, 1'b0, 32'h0000_0000, rd[31:0]);
      avs(REG_HI, 1'b0, 32'h0000_0000, rd[63:32]);
   endtask : get

   task automatic run();
      int n;
      n = 0;
      n_start = 0;
      n_err = 0;
      n_sg = 0;
      n_done = 0;
      unit_q.delete();
      len_q.delete();
      for (int i = 0; i < 8; i++) put(i, d[i]);
      avs(REG_FETCH, 1'b1, 32'h0000_0000, junk);
      while (busy !== 1'b1 && n < 50) begin
         @(posedge CLK);
         n++;
      end
      while (busy !== 1'b0 && n < 500) begin
         @(posedge CLK);
         n++;
      end
      if (n >= 500) err_total++;
      repeat (4) @(posedge CLK);
   endtask : run

   initial begin
      repeat (30000) @(posedge CLK);
      err_total++;
      end_of_test();
   end

   initial begin
      {irq_en, wb_en, host_wr_valid, host_wr_data, result_data} <= '0;
      repeat (8) @(posedge CLK);
      RST <= 1'b0;
      // Direct unit write with no descriptor
      @(posedge CLK);
      host_wr_valid <= 1'b1;
      host_wr_data <= 64'h0123_4567_89AB_CDEF;
      @(posedge CLK);
      host_wr_valid <= 1'b0;
      repeat (3) @(posedge CLK);
      chk(unit_q.size(), 1);
      chk(unit_q.pop_front(), 64'h0123_4567_89AB_CDEF);
      // Skip, direct read, length only, gather, store, writeback
      irq_en <= 1'b1;
      wb_en <= 1'b1;
      result_data <= 64'hFEED_0000_C0DE_0001;
      for (int i = 16; i < 19; i++) put(i, {16'hD00D, 16'(i), 16'hBEEF, 16'(i)});
      put(20, {32'h0000_0090, 8'h00, 1'b0, 1'b1, 6'h00, 16'h0008});
      d = '{hdr(UNIT_DES, 8'hA5, UNIT_DIGEST, 8'h3C, T_IPSEC, 1'b1, 1'b1),
         ptr(16'h0, 1'b0, 7'h0, 32'h80), ptr(16'h10, 1'b0, 7'h0, 32'h80),
         ptr(16'h5, 1'b0, 7'h3, 32'h0), ptr(16'h8, 1'b1, 7'h0, 32'hA0), 64'h0, 64'h0,
         ptr(16'h8, 1'b0, 7'h0, 32'hC0)};
      run();
      chk(n_start, 1);
      chk(pm_reg, {8'hA5, 56'h0});
      chk(sm_reg, {8'h3C, 56'h0});
      chk(inbound, 1'b1);
      chk(unit_q.size(), 3);
      for (int i = 16; i < 19; i++) begin
         chk(unit_q.pop_front(), {16'hD00D, 16'(i), 16'hBEEF, 16'(i)});
      end
      chk(len_q.size(), 4);
      chk(len_q.pop_front(), {7'h0, 16'h10});
      chk(len_q.pop_front(), {7'h3, 16'h5});
      chk(len_q.pop_front(), {7'h0, 16'h8});
      chk(n_done, 1);
      get(24);
      chk(rd, 64'hFEED_0000_C0DE_0001);
      get(0);
      chk(rd, {d[0][63:8], WB_MARK});
      // Zero segment length in a link table
      put(20, {32'h0000_0090, 8'h00, 1'b0, 1'b0, 6'h00, 16'h0000});
      d = '{hdr(UNIT_AES, 8'h01, UNIT_NONE, 8'h00, T_CCMP, 1'b0, 1'b1), 64'h0,
         ptr(16'h8, 1'b1, 7'h0, 32'hA0), 64'h0, 64'h0, 64'h0, 64'h0, 64'h0};
      run();
      chk(n_sg, 1);
      chk(n_done, 0);
      // Counter mode on the common type: context led by a zero dword
      put(16, 64'h0);
      put(17, 64'h0123_0000_0000_0CA7);
      d = '{hdr(UNIT_AES, 8'h01, UNIT_NONE, 8'h00, T_COMMON, 1'b0, 1'b0),
         ptr(16'h10, 1'b0, 7'h0, 32'h80), 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0};
      run();
      chk(unit_q.pop_front(), 64'h0);
      chk(unit_q.pop_front(), 64'h0123_0000_0000_0CA7);
      // Bad select pairs and reserved types
      for (int i = 0; i < 10; i++) begin
         d = '{hdr(bad[i][12:9], 8'h11, bad[i][8:5], 8'h22, bad[i][4:0], 1'b0, 1'b1),
            ptr(16'h8, 1'b0, 7'h0, 32'h80), 64'h0, 64'h0, 64'h0, 64'h0, 64'h0, 64'h0};
         run();
         chk(n_err, 1);
         chk(n_start + unit_q.size() + n_done, 0);
      end
      // Every decodable type, primary unit codes 1 to 6, all enable pairs
      for (int i = 0; i < 15; i++) begin
         ps = 4'(1 + i % 6);
         ss = (ps == UNIT_DES || ps == UNIT_AES || ps == UNIT_STREAM) ? UNIT_DIGEST : UNIT_NONE;
         pm = 8'(i * 17);
         irq_en <= i[1];
         wb_en <= i[2];
         d = '{hdr(ps, pm, ss, ~pm, types[i], i[0], 1'b1), 64'h0, 64'h0, 64'h0, 64'h0, 64'h0,
            64'h0, 64'h0};
         run();
         chk({n_start, n_err}, {32'd1, 32'd0});
         chk({psel, ssel}, {ps, ss});
         chk(pm_reg, {pm, 56'h0});
         if (ss == UNIT_DIGEST) begin
            chk(sm_reg, {~pm, 56'h0});
         end
         chk({dtype, newer, inbound}, {types[i], types[i][0], i[0]});
         chk(n_done, i[1]);
         get(0);
         chk(rd, i[2] ? {d[0][63:8], WB_MARK} : d[0]);
      end
      // Address queued while busy waits; a third one while pending is dropped
      n_start = 0;
      wb_en <= 1'b0;
      put(0, d[0]);
      for (int i = 0; i < 3; i++) avs(REG_FETCH, 1'b1, 32'h0000_0000, junk);
      avs(REG_STATUS, 1'b0, 32'h0000_0000, rd[31:0]);
      chk(rd[31:0], 32'h0000_0101);
      repeat (100) @(posedge CLK);
      chk(n_start, 2);
      end_of_test();
   end
endmodule : tb_top
